// *** design/ttc_cfg.svh ***
// constants for the triple timer/counter unit: addresses, bit positions, resets, timing
// Overview of operation
// - overflow sets timer flag; interrupt vectoring clears it
// - run bit low stops the timer, except timer B while timer A is split
// - pin interrupt sets edge flag; vectoring clears
// - type bit: low level or falling edge
// - gate bit makes counting need pin high
// - source select: prescaled clock or pin edges
// - modes: prescaled 8-bit, 16-bit, reload, split/halt
// - split mode: high byte uses timer B controls
// - reload mode reloads low byte from high
// - timer A count bytes reset to zero
// - timer C: 16-bit, selectable source, run bit
// - up/down enable: direction from direction pin
// - up overflow past FFFFh: flag, reload pair
// - down underflow at reload pair: flag, FFFFh
// - external flag toggles per wrap, no interrupt
// - timer mode advances once per six clocks
// - counter mode samples pin once per cycle
`ifndef TTC_CFG_SVH
`define TTC_CFG_SVH
// ====================================================
// special function register addresses
`define ADDR_TIMER_RUN_AND_IRQ_CONTROL 8'h88
`define ADDR_TIMER_MODE_SELECT 8'h89
`define ADDR_TIMER_A_COUNT_LOW 8'h8A
`define ADDR_TIMER_B_COUNT_LOW 8'h8B
`define ADDR_TIMER_A_COUNT_HIGH 8'h8C
`define ADDR_TIMER_B_COUNT_HIGH 8'h8D
`define ADDR_TIMER_C_CONTROL 8'hC8
`define ADDR_TIMER_C_MODE 8'hC9
`define ADDR_TIMER_C_RELOAD_LOW 8'hCA
`define ADDR_TIMER_C_RELOAD_HIGH 8'hCB
`define ADDR_TIMER_C_COUNT_LOW 8'hCC
`define ADDR_TIMER_C_COUNT_HIGH 8'hCD
// ====================================================
// control register bit positions
`define BIT_TIMER_B_OVERFLOW_FLAG 7
`define BIT_TIMER_B_RUN 6
`define BIT_TIMER_A_OVERFLOW_FLAG 5
`define BIT_TIMER_A_RUN 4
`define BIT_EXT_IRQ_B_EDGE_FLAG 3
`define BIT_EXT_IRQ_B_TYPE 2
`define BIT_EXT_IRQ_A_EDGE_FLAG 1
`define BIT_EXT_IRQ_A_TYPE 0
// mode register bit positions
`define BIT_TIMER_B_GATE_ENABLE 7
`define BIT_TIMER_B_SOURCE_SELECT 6
`define BIT_TIMER_B_MODE_LO 4
`define BIT_TIMER_A_GATE_ENABLE 3
`define BIT_TIMER_A_SOURCE_SELECT 2
`define BIT_TIMER_A_MODE_LO 0
// timer C control and mode bit positions
`define BIT_TIMER_C_OVERFLOW_FLAG 7
`define BIT_TIMER_C_EXTERNAL_FLAG 6
`define BIT_TIMER_C_RUN 2
`define BIT_TIMER_C_SOURCE_SELECT 1
`define BIT_TIMER_C_UPDOWN_ENABLE 0
// ====================================================
// reset values
`define RESET_CONTROL 8'h00
`define RESET_MODE 8'h00
`define RESET_COUNT 8'h00
// ====================================================
// timing: one peripheral cycle is six clocks
`define SYS_CLK_PERIOD_NS 25
`define PERIPHERAL_CYCLE_NS 150
`define PERIPHERAL_DIV (`PERIPHERAL_CYCLE_NS / `SYS_CLK_PERIOD_NS)
`endif

// *** design/ttc_pkg.sv ***
// types shared by the timer/counter modules
package ttc_pkg;
  typedef logic [7:0] byte_t;
  // decoded operating mode of timer A or B
  typedef enum logic [3:0] {
    MODE_PRESCALE = 4'b0001,
    MODE_WIDE = 4'b0010,
    MODE_RELOAD = 4'b0100,
    MODE_SPLIT = 4'b1000
  } timer_mode_t;
  // timer C state
  typedef struct packed {
    byte_t count_low;
    byte_t count_high;
    byte_t reload_low;
    byte_t reload_high;
    logic overflow_flag;
    logic external_flag;
    logic run;
    logic source_select;
    logic updown_enable;
    logic pin_prev;
  } timer_c_state_t;
endpackage

// *** design/timer_c_if.sv ***
// carrier between the register front end and timer C
`timescale 1ns/10ps
interface timer_c_if;
  logic tick;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq;
  logic count_pin;
  logic direction_pin;
  modport front (output tick, wr, addr, wdata, count_pin, direction_pin, input rdata, irq);
  modport unit (input tick, wr, addr, wdata, count_pin, direction_pin, output rdata, irq);
endinterface

// *** design/timer_c_unit.sv ***
// timer C: 16-bit auto-reload up/down counter with its registers
`timescale 1ns/10ps
`include "ttc_cfg.svh"
module timer_c_unit (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  timer_c_if.unit bus
);
  import ttc_pkg::*;
  timer_c_state_t cur;
  timer_c_state_t next_state;
  logic [15:0] count;
  logic [15:0] reload;
  logic inc;
  logic up;
  logic wrap;
  // ====================================================
  // next state
  always_comb
  begin
    next_state = cur;
    count = {cur.count_high, cur.count_low};
    reload = {cur.reload_high, cur.reload_low};
    inc = 1'b0;
    up = 1'b1;
    wrap = 1'b0;
    if (bus.tick)
    begin
      next_state.pin_prev = bus.count_pin;
      inc = cur.run & (cur.source_select ? (cur.pin_prev & ~bus.count_pin) : 1'b1);
    end
    up = ~cur.updown_enable | bus.direction_pin;
    if (inc)
    begin
      if (up)
      begin
        wrap = (count == 16'hFFFF);
        count = wrap ? reload : count + 16'h0001;
      end
      else
      begin
        wrap = (count == reload);
        count = wrap ? 16'hFFFF : count - 16'h0001;
      end
    end
    next_state.count_low = count[7:0];
    next_state.count_high = count[15:8];
    // software writes land before the hardware flag sets
    if (bus.wr)
    begin
      unique case (bus.addr)
        `ADDR_TIMER_C_CONTROL:
        begin
          next_state.overflow_flag = bus.wdata[`BIT_TIMER_C_OVERFLOW_FLAG];
          next_state.external_flag = bus.wdata[`BIT_TIMER_C_EXTERNAL_FLAG];
          next_state.run = bus.wdata[`BIT_TIMER_C_RUN];
          next_state.source_select = bus.wdata[`BIT_TIMER_C_SOURCE_SELECT];
        end
        `ADDR_TIMER_C_MODE: next_state.updown_enable = bus.wdata[`BIT_TIMER_C_UPDOWN_ENABLE];
        `ADDR_TIMER_C_RELOAD_LOW: next_state.reload_low = bus.wdata;
        `ADDR_TIMER_C_RELOAD_HIGH: next_state.reload_high = bus.wdata;
        `ADDR_TIMER_C_COUNT_LOW: next_state.count_low = bus.wdata;
        `ADDR_TIMER_C_COUNT_HIGH: next_state.count_high = bus.wdata;
        default: next_state = next_state;
      endcase
    end
    if (wrap)
    begin
      next_state.overflow_flag = 1'b1;
      if (cur.updown_enable)
      begin
        next_state.external_flag = ~next_state.external_flag;
      end
    end
  end
  // ====================================================
  // read mux and interrupt request
  always_comb
  begin
    unique case (bus.addr)
      `ADDR_TIMER_C_CONTROL: bus.rdata = {cur.overflow_flag, cur.external_flag, 3'h0, cur.run,
        cur.source_select, 1'b0};
      `ADDR_TIMER_C_MODE: bus.rdata = {7'h00, cur.updown_enable};
      `ADDR_TIMER_C_RELOAD_LOW: bus.rdata = cur.reload_low;
      `ADDR_TIMER_C_RELOAD_HIGH: bus.rdata = cur.reload_high;
      `ADDR_TIMER_C_COUNT_LOW: bus.rdata = cur.count_low;
      `ADDR_TIMER_C_COUNT_HIGH: bus.rdata = cur.count_high;
      default: bus.rdata = 8'h00;
    endcase
  end
  assign bus.irq = cur.overflow_flag | (cur.external_flag & ~cur.updown_enable);
  // state register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cur <= '0;
    end
    else if (clk_en_in)
    begin
      cur <= next_state;
    end
  end
endmodule

// *** design/triple_timer_counter_unit.sv ***
// timers A and B, external interrupt flags, register front end and timer C instance
`timescale 1ns/10ps
`include "ttc_cfg.svh"
module triple_timer_counter_unit (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] sfr_addr_in,
  input wire ttc_pkg::byte_t sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output ttc_pkg::byte_t sfr_rdata_out,
  input wire logic ext_irq_a_pin_in,
  input wire logic ext_irq_b_pin_in,
  input wire logic timer_a_count_pin_in,
  input wire logic timer_b_count_pin_in,
  input wire logic timer_c_count_pin_in,
  input wire logic timer_c_direction_pin_in,
  input wire logic timer_a_irq_ack_in,
  input wire logic timer_b_irq_ack_in,
  input wire logic ext_irq_a_ack_in,
  input wire logic ext_irq_b_ack_in,
  output logic timer_a_irq_out,
  output logic timer_b_irq_out,
  output logic ext_irq_a_irq_out,
  output logic ext_irq_b_irq_out,
  output logic timer_c_irq_out
);
  import ttc_pkg::*;

  // ====================================================
  // state of the front end and timers A and B
  typedef struct packed {
    byte_t control;
    byte_t mode_select;
    byte_t timer_a_low_byte;
    byte_t timer_a_high_byte;
    byte_t timer_b_low_byte;
    byte_t timer_b_high_byte;
    logic [2:0] divider;
    logic timer_a_pin_prev;
    logic timer_b_pin_prev;
    logic irq_a_pin_prev;
    logic irq_b_pin_prev;
    byte_t rdata;
  } front_state_t;

  localparam logic [2:0] DIV_LAST = 3'(`PERIPHERAL_DIV - 1);

  front_state_t cur;
  front_state_t next_state;
  timer_mode_t mode_a;
  timer_mode_t mode_b;
  logic tick;
  logic split;
  logic src_a;
  logic src_b;
  logic run_a;
  logic run_b;
  logic inc_a;
  logic inc_b;
  logic inc_split_high;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic [8:0] split_high;
  logic set_flag_a;
  logic set_flag_b;
  logic edge_a;
  logic edge_b;
  byte_t flags;
  byte_t rd_value;

  timer_c_if tc_bus ();

  // ====================================================
  // mode decode of a two-bit mode field
  function automatic timer_mode_t decode_mode(input logic [1:0] field);
    timer_mode_t m;
    m = MODE_PRESCALE;
    unique case (field)
      2'h0: m = MODE_PRESCALE;
      2'h1: m = MODE_WIDE;
      2'h2: m = MODE_RELOAD;
      2'h3: m = MODE_SPLIT;
    endcase
    return m;
  endfunction

  // ====================================================
  // one count step of a timer; result is {overflow, high, low}
  function automatic logic [16:0] timer_step(input timer_mode_t mode, input byte_t lo,
    input byte_t hi, input logic inc);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    if (inc)
    begin
      unique case (mode)
        MODE_PRESCALE:
        begin
          // five-bit prescaler in the low byte carries into the high byte
          r[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == 5'h1F)
          begin
            r[15:8] = hi + 8'h01;
            r[16] = (hi == 8'hFF);
          end
        end
        MODE_WIDE:
        begin
          r = {1'b0, hi, lo} + 17'h00001;
        end
        MODE_RELOAD:
        begin
          if (lo == 8'hFF)
          begin
            r[7:0] = hi;
            r[16] = 1'b1;
          end
          else
          begin
            r[7:0] = lo + 8'h01;
          end
        end
        MODE_SPLIT:
        begin
          // low byte alone; the high byte is stepped by the caller
          r[7:0] = lo + 8'h01;
          r[16] = (lo == 8'hFF);
        end
      endcase
    end
    return r;
  endfunction

  // ====================================================
  // peripheral cycle strobe
  always_comb
  begin
    tick = (cur.divider == DIV_LAST);
  end

  // ====================================================
  // count enables of timers A and B
  always_comb
  begin
    mode_a = decode_mode(cur.mode_select[`BIT_TIMER_A_MODE_LO +: 2]);
    mode_b = decode_mode(cur.mode_select[`BIT_TIMER_B_MODE_LO +: 2]);
    split = (mode_a == MODE_SPLIT);
    // counter operation counts a high sample followed by a low sample
    src_a = cur.mode_select[`BIT_TIMER_A_SOURCE_SELECT] ?
      (cur.timer_a_pin_prev & ~timer_a_count_pin_in) : 1'b1;
    src_b = cur.mode_select[`BIT_TIMER_B_SOURCE_SELECT] ?
      (cur.timer_b_pin_prev & ~timer_b_count_pin_in) : 1'b1;
    run_a = cur.control[`BIT_TIMER_A_RUN] &
      (~cur.mode_select[`BIT_TIMER_A_GATE_ENABLE] | ext_irq_a_pin_in);
    // while timer A is split, timer B loses its run bit and runs whenever its gate allows
    run_b = (split | cur.control[`BIT_TIMER_B_RUN]) &
      (~cur.mode_select[`BIT_TIMER_B_GATE_ENABLE] | ext_irq_b_pin_in);
    inc_a = tick & run_a & src_a;
    inc_b = tick & run_b & src_b & (mode_b != MODE_SPLIT);
    inc_split_high = tick & split & cur.control[`BIT_TIMER_B_RUN];
  end

  // ====================================================
  // count steps
  always_comb
  begin
    step_a = timer_step(mode_a, cur.timer_a_low_byte, cur.timer_a_high_byte, inc_a);
    step_b = timer_step(mode_b, cur.timer_b_low_byte, cur.timer_b_high_byte, inc_b);
    // split high byte counts peripheral cycles only
    split_high = {1'b0, cur.timer_a_high_byte} + {8'h00, inc_split_high};
    set_flag_a = step_a[16];
    set_flag_b = split ? split_high[8] : step_b[16];
    edge_a = cur.irq_a_pin_prev & ~ext_irq_a_pin_in;
    edge_b = cur.irq_b_pin_prev & ~ext_irq_b_pin_in;
  end

  // ====================================================
  // control register flags: write, then hardware clear, then hardware set
  always_comb
  begin
    flags = cur.control;
    if (sfr_wr_in && (sfr_addr_in == `ADDR_TIMER_RUN_AND_IRQ_CONTROL))
    begin
      flags = sfr_wdata_in;
    end
    if (timer_a_irq_ack_in)
    begin
      flags[`BIT_TIMER_A_OVERFLOW_FLAG] = 1'b0;
    end
    if (timer_b_irq_ack_in)
    begin
      flags[`BIT_TIMER_B_OVERFLOW_FLAG] = 1'b0;
    end
    if (set_flag_a)
    begin
      flags[`BIT_TIMER_A_OVERFLOW_FLAG] = 1'b1;
    end
    if (set_flag_b)
    begin
      flags[`BIT_TIMER_B_OVERFLOW_FLAG] = 1'b1;
    end
    // edge mode: falling edge sets, vectoring clears; level mode follows the inverted pin
    if (cur.control[`BIT_EXT_IRQ_A_TYPE])
    begin
      if (ext_irq_a_ack_in)
      begin
        flags[`BIT_EXT_IRQ_A_EDGE_FLAG] = 1'b0;
      end
      if (edge_a)
      begin
        flags[`BIT_EXT_IRQ_A_EDGE_FLAG] = 1'b1;
      end
    end
    else
    begin
      flags[`BIT_EXT_IRQ_A_EDGE_FLAG] = ~ext_irq_a_pin_in;
    end
    if (cur.control[`BIT_EXT_IRQ_B_TYPE])
    begin
      if (ext_irq_b_ack_in)
      begin
        flags[`BIT_EXT_IRQ_B_EDGE_FLAG] = 1'b0;
      end
      if (edge_b)
      begin
        flags[`BIT_EXT_IRQ_B_EDGE_FLAG] = 1'b1;
      end
    end
    else
    begin
      flags[`BIT_EXT_IRQ_B_EDGE_FLAG] = ~ext_irq_b_pin_in;
    end
  end

  // ====================================================
  // read multiplexer
  always_comb
  begin
    unique case (sfr_addr_in)
      `ADDR_TIMER_RUN_AND_IRQ_CONTROL: rd_value = cur.control;
      `ADDR_TIMER_MODE_SELECT: rd_value = cur.mode_select;
      `ADDR_TIMER_A_COUNT_LOW: rd_value = cur.timer_a_low_byte;
      `ADDR_TIMER_B_COUNT_LOW: rd_value = cur.timer_b_low_byte;
      `ADDR_TIMER_A_COUNT_HIGH: rd_value = cur.timer_a_high_byte;
      `ADDR_TIMER_B_COUNT_HIGH: rd_value = cur.timer_b_high_byte;
      default: rd_value = tc_bus.rdata;
    endcase
  end

  // ====================================================
  // next state of the front end
  always_comb
  begin
    next_state = cur;
    next_state.divider = tick ? 3'h0 : cur.divider + 3'h1;
    next_state.irq_a_pin_prev = ext_irq_a_pin_in;
    next_state.irq_b_pin_prev = ext_irq_b_pin_in;
    if (tick)
    begin
      next_state.timer_a_pin_prev = timer_a_count_pin_in;
      next_state.timer_b_pin_prev = timer_b_count_pin_in;
    end
    next_state.control = flags;
    next_state.timer_a_low_byte = step_a[7:0];
    next_state.timer_a_high_byte = split ? split_high[7:0] : step_a[15:8];
    next_state.timer_b_low_byte = step_b[7:0];
    next_state.timer_b_high_byte = step_b[15:8];
    // software writes override the count step of the same cycle
    if (sfr_wr_in)
    begin
      unique case (sfr_addr_in)
        `ADDR_TIMER_MODE_SELECT: next_state.mode_select = sfr_wdata_in;
        `ADDR_TIMER_A_COUNT_LOW: next_state.timer_a_low_byte = sfr_wdata_in;
        `ADDR_TIMER_B_COUNT_LOW: next_state.timer_b_low_byte = sfr_wdata_in;
        `ADDR_TIMER_A_COUNT_HIGH: next_state.timer_a_high_byte = sfr_wdata_in;
        `ADDR_TIMER_B_COUNT_HIGH: next_state.timer_b_high_byte = sfr_wdata_in;
        default: next_state.mode_select = next_state.mode_select;
      endcase
    end
    if (sfr_rd_in)
    begin
      next_state.rdata = rd_value;
    end
  end

  // ====================================================
  // state register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cur.control <= `RESET_CONTROL;
      cur.mode_select <= `RESET_MODE;
      cur.timer_a_low_byte <= `RESET_COUNT;
      cur.timer_a_high_byte <= `RESET_COUNT;
      cur.timer_b_low_byte <= `RESET_COUNT;
      cur.timer_b_high_byte <= `RESET_COUNT;
      cur.divider <= 3'h0;
      cur.timer_a_pin_prev <= 1'b0;
      cur.timer_b_pin_prev <= 1'b0;
      cur.irq_a_pin_prev <= 1'b1;
      cur.irq_b_pin_prev <= 1'b1;
      cur.rdata <= 8'h00;
    end
    else if (clk_en_in)
    begin
      cur <= next_state;
    end
  end

  // ====================================================
  // timer C
  assign tc_bus.tick = tick;
  assign tc_bus.wr = sfr_wr_in;
  assign tc_bus.addr = sfr_addr_in;
  assign tc_bus.wdata = sfr_wdata_in;
  assign tc_bus.count_pin = timer_c_count_pin_in;
  assign tc_bus.direction_pin = timer_c_direction_pin_in;

  timer_c_unit timer_c (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .bus(tc_bus)
  );

  // ====================================================
  // outputs
  assign sfr_rdata_out = cur.rdata;
  assign timer_a_irq_out = cur.control[`BIT_TIMER_A_OVERFLOW_FLAG];
  assign timer_b_irq_out = cur.control[`BIT_TIMER_B_OVERFLOW_FLAG];
  assign ext_irq_a_irq_out = cur.control[`BIT_EXT_IRQ_A_EDGE_FLAG];
  assign ext_irq_b_irq_out = cur.control[`BIT_EXT_IRQ_B_EDGE_FLAG];
  assign timer_c_irq_out = tc_bus.irq;
endmodule

// *** tb/ttc_cpu_model.sv ***
// partner model: processor core answering interrupt requests with vector acknowledges
`timescale 1ns/10ps
module ttc_cpu_model (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic slow_in,
  input wire logic [3:0] irq_in,
  output logic [3:0] ack_out
);
  logic [2:0] wait_cnt [4];
  // ==========================================
  // vectoring
  // after a prompt or slow delay, an acknowledge pulse per pending request, repeated while the request stays high
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!reset_n_in)
      begin
        ack_out[i] <= 1'b0;
        wait_cnt[i] <= 3'h0;
      end
      else if (irq_in[i] && !ack_out[i] && wait_cnt[i] >= (slow_in ? 3'h4 : 3'h0))
      begin
        ack_out[i] <= 1'b1;
        wait_cnt[i] <= 3'h0;
      end
      else
      begin
        ack_out[i] <= 1'b0;
        wait_cnt[i] <= irq_in[i] ? wait_cnt[i] + 3'h1 : 3'h0;
      end
    end
  end
endmodule

// *** tb/triple_timer_counter_unit_props.sv ***
// concurrent checks on the ports of the triple timer/counter unit
`timescale 1ns/10ps
module triple_timer_counter_unit_props (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire ttc_pkg::byte_t sfr_rdata_out,
  input wire logic ext_irq_a_pin_in,
  input wire logic ext_irq_b_pin_in,
  input wire logic timer_a_irq_ack_in,
  input wire logic timer_b_irq_ack_in,
  input wire logic timer_a_irq_out,
  input wire logic timer_b_irq_out,
  input wire logic ext_irq_a_irq_out,
  input wire logic ext_irq_b_irq_out,
  input wire logic timer_c_irq_out
);
  import ttc_pkg::*;
  logic ctrl_wr;
  logic c_wr;
  // software writes that may set or clear flags
  assign ctrl_wr = sfr_wr_in && clk_en_in && sfr_addr_in == 8'h88;
  assign c_wr = sfr_wr_in && clk_en_in && (sfr_addr_in == 8'hC8 || sfr_addr_in == 8'hC9);
  // ==========================================
  // assertions
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  tmr_a_clear_a: assert property (
    $fell(timer_a_irq_out) |-> $past(timer_a_irq_ack_in || ctrl_wr))
    else $error("timer a flag fell without ack or write");
  tmr_b_clear_a: assert property (
    $fell(timer_b_irq_out) |-> $past(timer_b_irq_ack_in || ctrl_wr))
    else $error("timer b flag fell without ack or write");
  tmr_c_clear_a: assert property (
    $fell(timer_c_irq_out) |-> $past(c_wr))
    else $error("timer c request fell without software write");
  ext_a_cause_a: assert property (
    $rose(ext_irq_a_irq_out) |-> $past(ctrl_wr) || !$past(ext_irq_a_pin_in)
      || !$past(ext_irq_a_pin_in, 2))
    else $error("ext a flag rose without low pin");
  ext_b_cause_a: assert property (
    $rose(ext_irq_b_irq_out) |-> $past(ctrl_wr) || !$past(ext_irq_b_pin_in)
      || !$past(ext_irq_b_pin_in, 2))
    else $error("ext b flag rose without low pin");
  tick_spacing_a: assert property (
    $rose(timer_a_irq_out) |=> (!$rose(timer_a_irq_out) || $past(ctrl_wr)) [*5])
    else $error("timer a flag rose twice within one peripheral cycle");
  frozen_state_a: assert property (
    !clk_en_in |=> $stable(timer_a_irq_out) && $stable(ext_irq_a_irq_out)
      && $stable(sfr_rdata_out))
    else $error("state moved while clock enable low");
  rdata_hold_a: assert property (
    !(sfr_rd_in && clk_en_in) |=> $stable(sfr_rdata_out))
    else $error("read data changed without a read");
  unmapped_read_a: assert property (
    sfr_rd_in && clk_en_in && sfr_addr_in inside {8'h00, 8'hFF} |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read returned nonzero");
  // main scenarios reached
  split_wrap_c: cover property ($rose(timer_b_irq_out));
  c_wrap_c: cover property ($rose(timer_c_irq_out));
  edge_ack_c: cover property (!ext_irq_a_pin_in ##1 $fell(ext_irq_a_irq_out));
endmodule
bind triple_timer_counter_unit triple_timer_counter_unit_props i_triple_timer_counter_unit_props (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
  .sfr_rdata_out(sfr_rdata_out), .ext_irq_a_pin_in(ext_irq_a_pin_in),
  .ext_irq_b_pin_in(ext_irq_b_pin_in), .timer_a_irq_ack_in(timer_a_irq_ack_in),
  .timer_b_irq_ack_in(timer_b_irq_ack_in), .timer_a_irq_out(timer_a_irq_out),
  .timer_b_irq_out(timer_b_irq_out), .ext_irq_a_irq_out(ext_irq_a_irq_out),
  .ext_irq_b_irq_out(ext_irq_b_irq_out), .timer_c_irq_out(timer_c_irq_out));

// *** tb/test_triple_timer_counter_unit.sv ***
// self-checking bench for the triple timer/counter unit
`timescale 1ns/10ps
module test_triple_timer_counter_unit;
  import ttc_pkg::*;
  logic sys_clk_in, reset_n_in, clk_en_in, sfr_wr_in, sfr_rd_in, dir, slow, cnt_b, rd_pend;
  logic [7:0] sfr_addr_in;
  byte_t sfr_wdata_in, sfr_rdata_out;
  logic [1:0] ext;
  wire logic [3:0] ack;
  wire logic [4:0] flg;
  logic [31:0] seed = 32'h45E2;
  logic [31:0] rv;
  logic [15:0] note;
  logic [15:0] exp_q [$];
  int n_fail = 0;
  int checks_done = 0;
  int n, m;
  logic [7:0] ra [14] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hC8, 8'hC9, 8'hCA,
    8'hCB, 8'hCC, 8'hCD, 8'h00, 8'hFF};
  // ==========================================
  // design and partner
  triple_timer_counter_unit i_triple_timer_counter_unit (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out), .ext_irq_a_pin_in(ext[0]),
    .ext_irq_b_pin_in(ext[1]), .timer_a_count_pin_in(cnt_b), .timer_b_count_pin_in(cnt_b),
    .timer_c_count_pin_in(cnt_b), .timer_c_direction_pin_in(dir),
    .timer_a_irq_ack_in(ack[0]), .timer_b_irq_ack_in(ack[1]), .ext_irq_a_ack_in(ack[2]),
    .ext_irq_b_ack_in(ack[3]), .timer_a_irq_out(flg[0]), .timer_b_irq_out(flg[1]),
    .ext_irq_a_irq_out(flg[2]), .ext_irq_b_irq_out(flg[3]), .timer_c_irq_out(flg[4]));
  ttc_cpu_model i_ttc_cpu_model (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .slow_in(slow),
    .irq_in(flg[3:0]), .ack_out(ack));
  // 40 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // ==========================================
  // helpers
  function logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checks_done++;
    if (got !== ex)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bus cycles: strobe held for the taking edge
  task automatic wr(input logic [7:0] a, input byte_t d);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    sfr_rd_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input byte_t e);
    exp_q.push_back({a, e});
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    sfr_wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  task automatic nop(input int c);
    sfr_wr_in <= 1'b0;
    sfr_rd_in <= 1'b0;
    repeat (c) @(posedge sys_clk_in);
  endtask
  // bounded wait for a request line to reach a level; n returns the cycles used
  task automatic wait_flag(input int i, input logic v, input int lim);
    n = 0;
    nop(0);
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (flg[i] !== v && n < lim);
    if (flg[i] !== v)
    begin
      chk($sformatf("request %0d timeout", i), v, flg[i]);
      tally_and_finish();
    end
  endtask
  // read results: the oldest note is compared one cycle after the taking edge
  always @(posedge sys_clk_in)
  begin
    if (rd_pend === 1'b1)
    begin
      note = exp_q.pop_front();
      chk($sformatf("reg %h", note[15:8]), note[7:0], sfr_rdata_out);
    end
    rd_pend <= sfr_rd_in && clk_en_in && reset_n_in;
  end
  // ==========================================
  // main sequence
  initial
  begin
    {reset_n_in, sfr_wr_in, sfr_rd_in, dir, slow, cnt_b} = 6'h00;
    {clk_en_in, ext, sfr_addr_in, sfr_wdata_in} = {3'h7, 16'h0000};
    repeat (6) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    wr(8'hFF, 8'hA5);
    for (int k = 0; k < 14; k++)
      rd(ra[k], 8'h00);
    for (int k = 2; k < 12; k++)
    begin
      rv = xorshift();
      if (k != 6 && k != 7)
        wr(ra[k], rv[7:0]);
      if (k != 6 && k != 7)
        rd(ra[k], rv[7:0]);
    end
    $display("test reset and readback done");
    wr(8'h8C, 8'hFE);
    wr(8'h8A, 8'hFE);
    wr(8'h89, 8'h02);
    wr(8'h88, 8'h10);
    wait_flag(0, 1'b1, 20);
    rd(8'h8A, 8'hFE);
    clk_en_in <= 1'b0;
    nop(6);
    clk_en_in <= 1'b1;
    wait_flag(0, 1'b0, 4);
    m = n;
    wait_flag(0, 1'b1, 20);
    chk("reload period", 16'd18, 16'(7 + m + n));
    wr(8'h88, 8'h00);
    $display("test reload mode done");
    wr(8'h8A, 8'h00);
    wr(8'h8C, 8'hFE);
    wr(8'h89, 8'h03);
    wr(8'h88, 8'h40);
    wait_flag(1, 1'b1, 14);
    wr(8'h88, 8'h00);
    rd(8'h8C, 8'h00);
    rd(8'h8A, 8'h00);
    $display("test split mode done");
    wr(8'h89, 8'h50);
    wr(8'h8B, 8'hFF);
    wr(8'h8D, 8'hFF);
    cnt_b <= 1'b1;
    wr(8'h88, 8'h40);
    nop(30);
    chk("counter idle", 16'h0, flg[1]);
    cnt_b <= 1'b0;
    wait_flag(1, 1'b1, 14);
    wr(8'h88, 8'h00);
    wr(8'h8B, 8'h10);
    wr(8'h89, 8'h30);
    wr(8'h88, 8'h40);
    nop(20);
    wr(8'h88, 8'h00);
    rd(8'h8B, 8'h10);
    $display("test counter and halt done");
    wr(8'h8A, 8'hFF);
    wr(8'h8C, 8'hFF);
    wr(8'h89, 8'h09);
    ext[0] <= 1'b0;
    wr(8'h88, 8'h10);
    nop(30);
    chk("gated", 16'h0, flg[0]);
    ext[0] <= 1'b1;
    wait_flag(0, 1'b1, 8);
    wr(8'h88, 8'h00);
    $display("test gate done");
    for (int i = 0; i < 2; i++)
    begin
      slow <= i[0];
      wr(8'h88, 8'h00);
      ext[i] <= 1'b0;
      wait_flag(2 + i, 1'b1, 4);
      nop(8);
      chk("level hold", 16'h1, flg[2 + i]);
      ext[i] <= 1'b1;
      wait_flag(2 + i, 1'b0, 4);
      wr(8'h88, i ? 8'h04 : 8'h01);
      ext[i] <= 1'b0;
      wait_flag(2 + i, 1'b1, 4);
      wait_flag(2 + i, 1'b0, 10);
      nop(4);
      chk("edge once", 16'h0, flg[2 + i]);
      ext[i] <= 1'b1;
    end
    $display("test external interrupts done");
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'h34);
    wr(8'hCD, 8'h12);
    wr(8'hC9, 8'h01);
    wr(8'hC8, 8'h04);
    wait_flag(4, 1'b1, 14);
    rd(8'hCC, 8'hFF);
    rd(8'hCD, 8'hFF);
    rd(8'hC8, 8'hC4);
    dir <= 1'b1;
    wr(8'hC8, 8'h44);
    wait_flag(4, 1'b1, 14);
    rd(8'hCC, 8'h34);
    rd(8'hCD, 8'h12);
    rd(8'hC8, 8'h84);
    wr(8'hC8, 8'h40);
    nop(2);
    chk("external flag request", 16'h0, flg[4]);
    wr(8'hC8, 8'h00);
    nop(4);
    $display("test timer c done");
    tally_and_finish();
  end
endmodule
